// >>> rtl/bit_instruction_port_rmw.sv
// Bit set and bit test-and-skip execution with read-modify-write port latches.
`timescale 1ns/1ns
// Functional notes
// - Bit-set opcode 0101 bbbf ffff sets register bit in one cycle, no flags.
// - Opcode 0110 skips next instruction when selected bit is zero.
// - Opcode 0111 skips next instruction when selected bit is one.
// - Taken skip discards next word, runs a no-op; the slot waits for that word, two cycles total if it comes at once.
// - Port bit change reads all pins, alters bit, writes whole latch.
// - Input pin latches get loaded with the pin level during modification.
// - Pin turned to output drives whatever its latch currently holds.
// - Port latches update at cycle end; pin reads sample at that same edge.
// - Port registers at 06h and 07h have six bits; upper bits read zero.
module bit_instruction_port_rmw
    import bit_port_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Instruction stream from the fetch stage.
    input wire logic instrValid,
    input wire logic [bit_port_pkg::INSTR_W-1:0] instrWord,
    // Direction load for the two ports, one means input.
    input wire logic dirLoadB,
    input wire logic dirLoadC,
    input wire logic [bit_port_pkg::PORT_W-1:0] dirData,
    // Pin levels seen at the port pads.
    input wire logic [bit_port_pkg::PORT_W-1:0] pinInB,
    input wire logic [bit_port_pkg::PORT_W-1:0] pinInC,
    // Pad drive for the two ports.
    output logic [bit_port_pkg::PORT_W-1:0] pinOutB,
    output logic [bit_port_pkg::PORT_W-1:0] pinOeB,
    output logic [bit_port_pkg::PORT_W-1:0] pinOutC,
    output logic [bit_port_pkg::PORT_W-1:0] pinOeC,
    // Execution status towards the pipeline.
    output logic skipActive,
    output logic retired,
    output logic [7:0] testValue
);
    import bit_port_pkg::*;

    // Every check in this module runs on mclk and rests during reset.
    default clocking assertClk @(posedge mclk);
    endclocking
    default disable iff (rst);

    exec_state_t state_reg, state_next;
    logic [7:0] fileMem [0:31];
    // Direction is held inverted so the pad enables come straight from flops.
    logic [PORT_W-1:0] latchB_reg, latchC_reg, oeB_reg, oeC_reg;
    logic skip_reg, retired_reg;
    logic [7:0] testValue_reg;

    wire logic [3:0] opcode = instrWord[11:8];
    wire logic [2:0] bitIdx = instrWord[7:5];
    wire logic [4:0] fileAddr = instrWord[4:0];
    wire logic execNow = instrValid && (state_reg == EXEC);
    wire logic isSet = execNow && (opcode == OP_BIT_SET);
    wire logic isSkipClr = execNow && (opcode == OP_SKIP_CLEAR);
    wire logic isSkipSet = execNow && (opcode == OP_SKIP_SET);
    wire logic hitB = fileAddr == ADDR_PORT_B;
    wire logic hitC = fileAddr == ADDR_PORT_C;
    // Ports read the pads, zero-extended, so tests see pin levels.
    wire logic [7:0] readValue = hitB ? {2'b00, pinInB} :
        hitC ? {2'b00, pinInC} : fileMem[fileAddr];
    wire logic [7:0] bitMask = 8'h01 << bitIdx;
    wire logic [7:0] setValue = readValue | bitMask;
    wire logic selBit = |(readValue & bitMask);
    wire logic skipTaken = (isSkipClr && !selBit) ||
        (isSkipSet && selBit);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            EXEC: if (skipTaken) state_next = FLUSH;
            FLUSH: if (instrValid) state_next = EXEC;
            default: state_next = EXEC;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg <= EXEC;
        end else begin
            state_reg <= state_next;
        end
    end

    // The file array keeps its contents over reset, as the core registers do.
    always_ff @(posedge mclk) begin
        if (isSet && !hitB && !hitC) begin
            fileMem[fileAddr] <= setValue;
        end
    end

    // Whole latch rewritten at cycle end, including bits of input pins.
    always_ff @(posedge mclk) begin
        if (rst) begin
            latchB_reg <= LATCH_RESET;
            latchC_reg <= LATCH_RESET;
            oeB_reg <= ~DIR_RESET;
            oeC_reg <= ~DIR_RESET;
        end else begin
            if (isSet && hitB) latchB_reg <= setValue[PORT_W-1:0];
            if (isSet && hitC) latchC_reg <= setValue[PORT_W-1:0];
            if (dirLoadB) oeB_reg <= ~dirData;
            if (dirLoadC) oeC_reg <= ~dirData;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            skip_reg <= 1'b0;
            retired_reg <= 1'b0;
            testValue_reg <= FILE_RESET;
        end else begin
            skip_reg <= state_next == FLUSH;
            retired_reg <= execNow;
            testValue_reg <= execNow ? readValue : testValue_reg;
        end
    end

    assign skipActive = skip_reg;
    assign retired = retired_reg;
    assign testValue = testValue_reg;
    // Output drive always takes the latch, whatever was last written to it.
    assign pinOutB = latchB_reg;
    assign pinOutC = latchC_reg;
    assign pinOeB = oeB_reg;
    assign pinOeC = oeC_reg;

    // The taken test, the no-op slot and the return to normal issue.
    sequence s_skip_taken;
        skipTaken;
    endsequence

    sequence s_flush_consume;
        instrValid && state_reg == FLUSH;
    endsequence

    a_skip_flush_cycle: assert property (
        s_skip_taken |=> state_reg == FLUSH && skipActive)
        else $error("taken skip did not flush next word");
    a_flush_waits: assert property (
        state_reg == FLUSH && !instrValid |=> state_reg == FLUSH && skipActive)
        else $error("no-op slot left before a word came");
    a_flush_no_retire: assert property (
        s_flush_consume |=> state_reg == EXEC && !skipActive && !retired)
        else $error("discarded word retired or slot stuck");
    a_flush_no_latch: assert property (
        s_flush_consume |=> $stable(pinOutB) && $stable(pinOutC))
        else $error("discarded word changed a port latch");

    // Each test decodes its own opcode and looks at the selected bit.
    a_noskip_when_clear: assert property (
        isSkipClr && selBit |=> state_reg == EXEC)
        else $error("clear test skipped on a set bit");
    a_skip_clear_taken: assert property (
        execNow && opcode == OP_SKIP_CLEAR && !readValue[bitIdx]
        |=> skipActive)
        else $error("clear test did not skip on a clear bit");
    a_noskip_when_set: assert property (
        isSkipSet && !selBit |=> state_reg == EXEC)
        else $error("set test skipped on a clear bit");
    a_skip_set_taken: assert property (
        execNow && opcode == OP_SKIP_SET && readValue[bitIdx]
        |=> skipActive)
        else $error("set test did not skip on a set bit");
    a_set_no_skip: assert property (
        isSet |=> !skipActive && retired)
        else $error("bit set skipped or did not retire");

    // Bit set on the file array and on the port latches.
    a_file_set: assert property (
        isSet && !hitB && !hitC |=> fileMem[$past(fileAddr)][$past(bitIdx)])
        else $error("file bit not set");
    a_set_bit_b: assert property (
        isSet && hitB && bitIdx < 3'h6 |=> pinOutB[$past(bitIdx)])
        else $error("port b bit not set");
    a_set_bit_c: assert property (
        isSet && hitC && bitIdx < 3'h6 |=> pinOutC[$past(bitIdx)])
        else $error("port c bit not set");
    a_rmw_port_b: assert property (
        isSet && hitB |=> pinOutB == ($past(pinInB) | $past(bitMask[5:0])))
        else $error("port b latch not pins with bit set");
    a_rmw_port_c: assert property (
        isSet && hitC |=> pinOutC == ($past(pinInC) | $past(bitMask[5:0])))
        else $error("port c latch not pins with bit set");
    a_input_latch_b: assert property (
        isSet && hitB |=> ((pinOutB ^ $past(pinInB))
            & ~$past(pinOeB | bitMask[5:0])) == 6'h00)
        else $error("port b input latch not loaded from pin");
    a_input_latch_c: assert property (
        isSet && hitC |=> ((pinOutC ^ $past(pinInC))
            & ~$past(pinOeC | bitMask[5:0])) == 6'h00)
        else $error("port c input latch not loaded from pin");

    // Outside reset, latches move only on a bit set; a direction change never alters them.
    a_drive_after_dir_b: assert property (
        dirLoadB && !(isSet && hitB) |=> $stable(pinOutB)
        && pinOeB == ~$past(dirData))
        else $error("port b direction load disturbed drive");
    a_drive_after_dir_c: assert property (
        dirLoadC && !(isSet && hitC) |=> $stable(pinOutC)
        && pinOeC == ~$past(dirData))
        else $error("port c direction load disturbed drive");
    a_latch_hold: assert property (
        !(isSet && hitB) |=> pinOutB == $past(pinOutB))
        else $error("port b latch changed without write");
    a_latch_hold_c: assert property (
        !(isSet && hitC) |=> pinOutC == $past(pinOutC))
        else $error("port c latch changed without write");

    // Port reads come from the pads, with the two upper bits zero.
    a_upper_bits_zero: assert property (
        execNow && (hitB || hitC) |=> testValue[7:6] == 2'b00)
        else $error("port upper bits not zero");
    a_pin_read_path: assert property (
        execNow && hitB |=> testValue[5:0] == $past(pinInB))
        else $error("port b test did not read pins");
    a_pin_read_c: assert property (
        execNow && hitC |=> testValue[5:0] == $past(pinInC))
        else $error("port c test did not read pins");
endmodule // bit_instruction_port_rmw

// >>> rtl/bit_port_pkg.sv
// Package holding encodings, addresses and widths for the bit instruction unit.
package bit_port_pkg;
    localparam int INSTR_W = 12;
    localparam int PORT_W = 6;
    localparam logic [3:0] OP_BIT_SET = 4'h5;
    localparam logic [3:0] OP_SKIP_CLEAR = 4'h6;
    localparam logic [3:0] OP_SKIP_SET = 4'h7;
    localparam logic [4:0] ADDR_PORT_B = 5'h06;
    localparam logic [4:0] ADDR_PORT_C = 5'h07;
    localparam logic [PORT_W-1:0] DIR_RESET = 6'h3F;
    localparam logic [PORT_W-1:0] LATCH_RESET = 6'h00;
    localparam logic [7:0] FILE_RESET = 8'h00;
    localparam int SKIP_CYCLES = 2;
    typedef enum logic [1:0] {
        EXEC = 2'b01,
        FLUSH = 2'b10
    } exec_state_t;
endpackage

// >>> verif/pin_load_model.sv
// Model of the outside circuitry that loads the port pads.
`timescale 1ns/1ns
module pin_load_model
    import bit_port_pkg::*;
(
    // Pad drive from the port.
    input wire logic [bit_port_pkg::PORT_W-1:0] pinOut,
    input wire logic [bit_port_pkg::PORT_W-1:0] pinOe,
    // Level that the outside world pulls a released pad to.
    input wire logic [bit_port_pkg::PORT_W-1:0] extLevel,
    // Level seen on the pads.
    output logic [bit_port_pkg::PORT_W-1:0] pinIn
);
    // A driven pad follows its latch; a released one shows the outside level.
    assign pinIn = (pinOut & pinOe) | (extLevel & ~pinOe);
endmodule // pin_load_model

// >>> verif/tb_bit_instruction_port_rmw.sv
// Self-checking bench for the bit instruction unit.
`timescale 1ns/1ns
module tb_bit_instruction_port_rmw;
    import bit_port_pkg::*;
    logic mclk = 0, rst = 1, instrValid = 0, dirLoadB = 0, dirLoadC = 0;
    logic [INSTR_W-1:0] instrWord = '0;
    logic [PORT_W-1:0] dirData = '0, extB = '0, extC = '0;
    logic [PORT_W-1:0] pinInB, pinInC, pinOutB, pinOeB, pinOutC, pinOeC;
    logic skipActive, retired;
    logic [7:0] testValue;
    int num_errors = 0, n_checks = 0, cycles = 0;
    always #50 mclk = ~mclk;
    bit_instruction_port_rmw dut (.mclk(mclk), .rst(rst),
        .instrValid(instrValid), .instrWord(instrWord),
        .dirLoadB(dirLoadB), .dirLoadC(dirLoadC), .dirData(dirData),
        .pinInB(pinInB), .pinInC(pinInC), .pinOutB(pinOutB),
        .pinOeB(pinOeB), .pinOutC(pinOutC), .pinOeC(pinOeC),
        .skipActive(skipActive), .retired(retired), .testValue(testValue));
    pin_load_model loadB (.pinOut(pinOutB), .pinOe(pinOeB),
        .extLevel(extB), .pinIn(pinInB));
    pin_load_model loadC (.pinOut(pinOutC), .pinOe(pinOeC),
        .extLevel(extC), .pinIn(pinInC));
    // The whole sequence needs well under 100 cycles.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("Checks %0d, errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] e,
            input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic run(input logic [INSTR_W-1:0] w);
        @(negedge mclk);
        instrValid = 1'b1;
        instrWord = w;
        @(negedge mclk);
        instrValid = 1'b0;
    endtask
    task automatic rmw_scenario();
        extB = 6'h15;
        run({OP_BIT_SET, 3'd5, ADDR_PORT_B});
        chk("latchB", {2'b00, 6'h15 | 6'h20}, {2'b00, pinOutB});
        chk("retired", 8'h01, {7'h00, retired});
        @(negedge mclk);
        dirLoadB = 1'b1;
        dirData = 6'h00;
        @(negedge mclk);
        dirLoadB = 1'b0;
        chk("oeB", 8'h3F, {2'b00, pinOeB});
        chk("driveB", 8'h35, {2'b00, pinOutB});
    endtask
    task automatic skip_clear_scenario();
        run({OP_SKIP_CLEAR, 3'd1, ADDR_PORT_B});
        chk("skipClr", 8'h01, {7'h00, skipActive});
        chk("testB", 8'h35, testValue);
        // The word in the no-op slot must leave port c alone.
        run({OP_BIT_SET, 3'd0, ADDR_PORT_C});
        chk("flushC", 8'h00, {2'b00, pinOutC});
        chk("flushRet", 8'h00, {7'h00, retired});
        run({OP_SKIP_CLEAR, 3'd0, ADDR_PORT_B});
        chk("noSkip", 8'h00, {7'h00, skipActive});
    endtask
    task automatic skip_set_scenario();
        run({OP_BIT_SET, 3'd7, 5'h10});
        run({OP_SKIP_SET, 3'd7, 5'h10});
        chk("skipSet", 8'h01, {7'h00, skipActive});
        run(12'h000);
        extC = 6'h3E;
        run({OP_SKIP_SET, 3'd0, ADDR_PORT_C});
        chk("setNoSkip", 8'h00, {7'h00, skipActive});
        chk("testC", 8'h3E, testValue);
    endtask
    task automatic reset_scenario();
        // Mid-run reset clears the ports; the file array keeps its bits.
        @(negedge mclk);
        rst = 1'b1;
        @(negedge mclk);
        rst = 1'b0;
        chk("rstLatchB", {2'b00, LATCH_RESET}, {2'b00, pinOutB});
        chk("rstOeB", {2'b00, ~DIR_RESET}, {2'b00, pinOeB});
        chk("rstTest", FILE_RESET, testValue);
        run({OP_SKIP_SET, 3'd7, 5'h10});
        chk("fileKept", 8'h01, {7'h00, skipActive});
        run(12'h000);
        chk("slotRet", 8'h00, {7'h00, retired});
    endtask
    task automatic port_c_scenario();
        // Upper two pins of port c stay inputs, the lower four drive.
        @(negedge mclk);
        dirLoadC = 1'b1;
        dirData = 6'h30;
        @(negedge mclk);
        dirLoadC = 1'b0;
        chk("oeC", 8'h0F, {2'b00, pinOeC});
        run({OP_BIT_SET, 3'd1, ADDR_PORT_C});
        chk("latchC", 8'h32, {2'b00, pinOutC});
        // Pins now disagree with the latch on bits 5 and 4.
        extC = 6'h0E;
        run(12'h000);
        run({OP_SKIP_CLEAR, 3'd5, ADDR_PORT_C});
        chk("testC2", 8'h02, testValue);
        chk("skipPinC", 8'h01, {7'h00, skipActive});
        run(12'h000);
        chk("keepC", 8'h32, {2'b00, pinOutC});
    endtask
    initial begin
        repeat (4) @(negedge mclk);
        rst = 1'b0;
        chk("rstOe", 8'h00, {2'b00, pinOeB});
        chk("rstLatch", {2'b00, LATCH_RESET}, {2'b00, pinOutB});
        rmw_scenario();
        skip_clear_scenario();
        skip_set_scenario();
        reset_scenario();
        port_c_scenario();
        wrap_up();
    end
endmodule // tb_bit_instruction_port_rmw
